//--- acquisition_sequencer.sv
// acquisition sequencer: temperature, then x, y, z, spaced in time
`timescale 1ns/1ps
`include "sensor_output_params.svh"
module acquisition_sequencer #(
   parameter int GAP_CYCLES = 5000
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic odr_tick_i,
   input wire logic adc_done_i,
   input wire logic [11:0] adc_data_i,
   output logic adc_start_o,
   output logic [1:0] adc_channel_o,
   output logic sample_valid_o,
   output logic [7:0] temp_o,
   output logic [11:0] x_o,
   output logic [11:0] y_o,
   output logic [11:0] z_o
);
   sensor_output_pkg::seq_regs_t q, d; // state and next state

   // next state: one conversion per rate tick
   always_comb begin
      d = q;
      d.start = 1'b0;
      d.valid = 1'b0;
      if (q.timer != 16'h0000) begin
         d.timer = q.timer - 16'h0001;
      end
      case (q.st)
         sensor_output_pkg::SEQ_IDLE: begin
            if (odr_tick_i) begin
               d.chan = `CHAN_TEMP; // temperature first
               d.st = sensor_output_pkg::SEQ_START;
            end
         end
         sensor_output_pkg::SEQ_START: begin
            // start only once the spacing has run out
            if (q.timer == 16'h0000) begin
               d.start = 1'b1;
               d.timer = 16'(GAP_CYCLES - 1);
               d.st = sensor_output_pkg::SEQ_WAIT;
            end
         end
         sensor_output_pkg::SEQ_WAIT: begin
            if (adc_done_i) begin
               case (q.chan)
                  `CHAN_TEMP: d.temp = adc_data_i[7:0];
                  `CHAN_X: d.x = adc_data_i;
                  `CHAN_Y: d.y = adc_data_i;
                  default: d.z = adc_data_i;
               endcase
               if (q.chan == `CHAN_Z) begin
                  d.valid = 1'b1; // whole sample ready
                  d.st = sensor_output_pkg::SEQ_IDLE;
               end else begin
                  d.chan = q.chan + 2'h1; // x, y, z in turn
                  d.st = sensor_output_pkg::SEQ_START;
               end
            end
         end
         default: d.st = sensor_output_pkg::SEQ_IDLE;
      endcase
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign adc_start_o = q.start;
   assign adc_channel_o = q.chan;
   assign sample_valid_o = q.valid;
   assign temp_o = q.temp;
   assign x_o = q.x;
   assign y_o = q.y;
   assign z_o = q.z;

   // a conversion always opens with the temperature channel
   a_temp_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && q.st == sensor_output_pkg::SEQ_IDLE && odr_tick_i |=> q.chan == `CHAN_TEMP)
      else $error("conversion did not start with temperature");
   // after a start the next one waits out the full spacing
   a_gap_held: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && q.start |-> q.timer == 16'(GAP_CYCLES - 1))
      else $error("acquisition spacing not loaded");
endmodule // acquisition_sequencer

//--- host_model.sv
// host model: issues register reads and writes on the device's host port
`timescale 1ns/1ps
module host_model (
   input wire logic ref_clk_i,
   output logic rd_en_o,
   output logic wr_en_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // idle host port at time zero
   initial begin
      rd_en_o = 1'b0;
      wr_en_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // one read, entered just after an edge; more keeps the strobe up for a burst
   task automatic read(input logic [7:0] a, input logic more);
      rd_en_o = 1'b1;
      addr_o = a;
      @(posedge ref_clk_i);
      #1;
      if (!more) begin
         rd_en_o = 1'b0;
         addr_o = ~a; // released address no longer shows the last value
         @(posedge ref_clk_i); // an edge passes before the next request
         #1;
      end
   endtask

   // one write; the device must ignore it
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      wr_en_o = 1'b1;
      addr_o = a;
      wdata_o = d;
      @(posedge ref_clk_i);
      #1;
      wr_en_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      @(posedge ref_clk_i); // an edge passes before the next request
      #1;
   endtask

   // big-endian pair to 12-bit value: shift right four, sign handled by host
   function automatic logic [11:0] unpack_be(input logic [7:0] lo, input logic [7:0] hi);
      return 12'({lo, hi} >> 4);
   endfunction
endmodule // host_model

//--- sensor_output_data_regs.sv
// read-only output data register group of a 3-axis accelerometer
`timescale 1ns/1ps
`include "sensor_output_params.svh"
// Summary of operation
// - temperature is 8-bit two's complement
// - temperature zero means 25 degrees c
// - temperature refreshed every output sample period
// - magnitude computed only while enable set
// - magnitude register read clears data ready
// - magnitude at 02h/03h, upper bits zero in little endian
// - endian select orders magnitude and axes
// - x, y, z 12-bit over 04h-09h
// - all results latch with data ready
// - fast read skips axis high bytes in bursts
// - fast read puts axis high byte at low
// - little endian: low byte first, sign-extended
// - big endian: high byte first, nibble left
// - temperature then x, y, z, 40 us
// - axis register read clears data ready
// - sign bits copy axis bit 11
module sensor_output_data_regs #(
   parameter int GAP_CYCLES = `ACQ_GAP_NS / `CLK_PERIOD_NS // acquisition spacing
) (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic odr_tick_i, // one pulse per output sample period
   input wire logic adc_done_i, // converter has a result
   input wire logic [11:0] adc_data_i, // converter result
   output logic adc_start_o, // start a conversion
   output logic [1:0] adc_channel_o, // channel being converted
   input wire logic magnitude_calc_enable_i, // magnitude calculation on
   input wire logic endian_select_i, // 1 selects big endian
   input wire logic fast_read_i, // 1 selects fast read
   input wire logic rd_en_i, // host read strobe
   input wire logic wr_en_i, // host write strobe
   input wire logic [7:0] addr_i, // host register address
   input wire logic [7:0] wdata_i, // host write data, never stored
   output logic [7:0] rdata_o, // read data
   output logic [7:0] next_addr_o, // burst address after this read
   output logic data_ready_flag_o // new sample ready
);
   sensor_output_pkg::bank_regs_t q, d; // state and next state
   logic seq_valid; // sequencer has a full sample
   logic [7:0] seq_temp; // raw temperature code
   logic [11:0] seq_x; // raw x
   logic [11:0] seq_y; // raw y
   logic [11:0] seq_z; // raw z
   logic mag_start; // launch a magnitude calculation
   logic mag_done; // magnitude ready
   logic [11:0] mag_value; // magnitude result
   logic latch; // take the new sample now

   // refuse a spacing that the sequencer timer cannot hold
   if (GAP_CYCLES < 1 || GAP_CYCLES > 65535) begin : g_gap_check
      $error("GAP_CYCLES out of range");
   end

   // one byte of a 12-bit value for a given order and half
   function automatic logic [7:0] pick_byte(
      input logic [11:0] v, // value
      input logic hi, // 1 for the upper address of the pair
      input logic sgn, // 1 for a signed axis value
      input logic be, // big endian
      input logic fr // fast read
   );
      logic [7:0] b;
      b = v[7:0]; // little endian low byte
      if (!hi && (be || (fr && sgn))) begin
         b = v[11:4]; // high byte at lower address
      end else if (hi && be) begin
         b = {v[3:0], 4'h0}; // low nibble left justified
      end else if (hi) begin
         // upper nibble right justified, filled with sign or zero
         b = {(sgn ? {4{v[11]}} : 4'h0), v[11:8]};
      end
      return b;
   endfunction

   // true for addresses whose read clears the data ready flag
   function automatic logic clears_ready(input logic [7:0] a);
      return a >= `ADDR_VECTOR_MAGNITUDE_LOW && a <= `ADDR_Z_HIGH;
   endfunction

   // true for the lower address of an axis pair
   function automatic logic axis_low(input logic [7:0] a);
      return a == `ADDR_X_LOW || a == `ADDR_Y_LOW || a == `ADDR_Z_LOW;
   endfunction

   // read data for one address
   function automatic logic [7:0] read_byte(
      input logic [7:0] a,
      input sensor_output_pkg::bank_regs_t r,
      input logic be,
      input logic fr
   );
      logic [7:0] b;
      b = `DATA_RESET; // unmapped addresses read zero
      case (a)
         `ADDR_TEMPERATURE: b = r.temp;
         `ADDR_VECTOR_MAGNITUDE_LOW: b = pick_byte(r.vector_magnitude, 1'b0, 1'b0, be, fr);
         `ADDR_VECTOR_MAGNITUDE_HIGH: b = pick_byte(r.vector_magnitude, 1'b1, 1'b0, be, fr);
         `ADDR_X_LOW: b = pick_byte(r.x, 1'b0, 1'b1, be, fr);
         `ADDR_X_HIGH: b = pick_byte(r.x, 1'b1, 1'b1, be, fr);
         `ADDR_Y_LOW: b = pick_byte(r.y, 1'b0, 1'b1, be, fr);
         `ADDR_Y_HIGH: b = pick_byte(r.y, 1'b1, 1'b1, be, fr);
         `ADDR_Z_LOW: b = pick_byte(r.z, 1'b0, 1'b1, be, fr);
         `ADDR_Z_HIGH: b = pick_byte(r.z, 1'b1, 1'b1, be, fr);
         default: b = `DATA_RESET;
      endcase
      return b;
   endfunction

   // temperature then x, y, z, spaced by the acquisition gap
   acquisition_sequencer #(
      .GAP_CYCLES(GAP_CYCLES)
   ) u_sequencer (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .odr_tick_i(odr_tick_i),
      .adc_done_i(adc_done_i),
      .adc_data_i(adc_data_i),
      .adc_start_o(adc_start_o),
      .adc_channel_o(adc_channel_o),
      .sample_valid_o(seq_valid),
      .temp_o(seq_temp),
      .x_o(seq_x),
      .y_o(seq_y),
      .z_o(seq_z)
   );

   // magnitude runs only while enabled
   assign mag_start = seq_valid && magnitude_calc_enable_i;

   // square root of the sum of squares
   vector_magnitude_calc u_magnitude (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .start_i(mag_start),
      .x_i(seq_x),
      .y_i(seq_y),
      .z_i(seq_z),
      .done_o(mag_done),
      .mag_o(mag_value)
   );

   // latch when the magnitude is done, or at once if it is not computed
   assign latch = (seq_valid && !magnitude_calc_enable_i) || mag_done;

   // next state: host reads and sample latching
   always_comb begin
      d = q;
      if (rd_en_i) begin
         d.rdata = read_byte(addr_i, q, endian_select_i, fast_read_i);
         if (fast_read_i && axis_low(addr_i)) begin
            d.next_addr = 8'(addr_i + 8'h02); // skip the high byte
         end else begin
            d.next_addr = 8'(addr_i + 8'h01); // plain auto-increment
         end
         if (clears_ready(addr_i)) begin
            d.drdy = 1'b0; // read of a magnitude or axis register
         end
      end
      // wr_en_i and wdata_i never reach the state
      if (latch) begin
         d.temp = 8'(seq_temp - `TEMP_ZERO_CODE); // zero reads as 25 degrees c
         d.x = seq_x;
         d.y = seq_y;
         d.z = seq_z;
         if (mag_done) begin
            d.vector_magnitude = mag_value;
         end
         d.drdy = 1'b1; // set wins over a clearing read
      end
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0; // magnitude and flag reset to zero
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign rdata_o = q.rdata;
   assign next_addr_o = q.next_addr;
   assign data_ready_flag_o = q.drdy;

   // a latch raises the flag and loads x and z together
   a_latch_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && latch |=> q.drdy && q.x == $past(seq_x) && q.z == $past(seq_z))
      else $error("sample not latched with data ready");

   // reading a magnitude register clears the flag
   a_vector_magnitude_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && !latch && (addr_i == `ADDR_VECTOR_MAGNITUDE_LOW || addr_i == `ADDR_VECTOR_MAGNITUDE_HIGH)
      |=> !q.drdy)
      else $error("magnitude read left data ready set");

   // reading an axis register clears the flag
   a_axis_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && !latch && addr_i >= `ADDR_X_LOW && addr_i <= `ADDR_Z_HIGH
      |=> !q.drdy)
      else $error("axis read left data ready set");

   // temperature read returns the register
   a_temp_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_TEMPERATURE |=> rdata_o == $past(q.temp))
      else $error("temperature read mismatch");

   // little endian high byte carries four sign copies
   a_le_sign: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_Y_HIGH && !endian_select_i
      |=> rdata_o == {{4{$past(q.y[11])}}, $past(q.y[11:8])})
      else $error("little endian high byte wrong");

   // big endian pair: low nibble on the left at the upper address
   a_be_pair: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_X_HIGH && endian_select_i
      |=> rdata_o == {$past(q.x[3:0]), 4'h0})
      else $error("big endian low nibble wrong");

   // fast read puts the high byte at the low address
   a_fast_msb: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_Z_LOW && fast_read_i
      |=> rdata_o == $past(q.z[11:4]))
      else $error("fast read byte wrong");

   // fast read burst steps over the high byte
   a_fast_skip: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && axis_low(addr_i) && fast_read_i
      |=> next_addr_o == 8'($past(addr_i) + 8'h02))
      else $error("fast read did not skip high byte");

   // little endian magnitude high register keeps its top nibble zero
   a_vector_magnitude_upper: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_VECTOR_MAGNITUDE_HIGH && !endian_select_i
      |=> rdata_o[7:4] == 4'h0)
      else $error("magnitude upper bits not zero");

   // with the calculation off the magnitude stays put
   a_vector_magnitude_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && !mag_done |=> $stable(q.vector_magnitude))
      else $error("magnitude changed without a calculation");

   // a write alone changes no data register
   a_write_ignored: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && wr_en_i && !rd_en_i && !latch |=> $stable(q))
      else $error("write changed register contents");

   // clock enable low holds every register
   a_ce_freeze: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !ce_i |=> $stable(q))
      else $error("state changed while clock enable low");

   // a latch loads the temperature of the same sample
   a_temp_latch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && latch |=> q.temp == 8'($past(seq_temp) - `TEMP_ZERO_CODE))
      else $error("temperature not latched");

   // a latch loads y together with x and z
   a_y_latch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && latch |=> q.y == $past(seq_y))
      else $error("y not latched with the sample");

   // the flag rises only with a latch
   a_flag_rise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && !latch |=> !$rose(q.drdy))
      else $error("data ready rose without a latch");

   // a finished calculation loads the magnitude
   a_vector_magnitude_load: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && mag_done |=> q.vector_magnitude == $past(mag_value))
      else $error("magnitude result not loaded");

   // little endian magnitude low byte
   a_vector_magnitude_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_VECTOR_MAGNITUDE_LOW && !endian_select_i
      |=> rdata_o == $past(q.vector_magnitude[7:0]))
      else $error("magnitude low byte wrong");

   // little endian axis low byte at the lower address
   a_le_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_X_LOW && !endian_select_i && !fast_read_i
      |=> rdata_o == $past(q.x[7:0]))
      else $error("little endian low byte wrong");

   // big endian puts the high byte at the lower address
   a_be_msb: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_Y_LOW && endian_select_i
      |=> rdata_o == $past(q.y[11:4]))
      else $error("big endian high byte wrong");

   // little endian z high byte carries four copies of the sign
   a_z_sign: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && addr_i == `ADDR_Z_HIGH && !endian_select_i
      |=> rdata_o[7:4] == {4{$past(q.z[11])}})
      else $error("z sign bits wrong");

   // without fast read the burst address steps by one
   a_plain_step: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ce_i && rd_en_i && !fast_read_i |=> next_addr_o == 8'($past(addr_i) + 8'h01))
      else $error("plain burst step wrong");
endmodule // sensor_output_data_regs

//--- sensor_output_data_regs_tb.sv
// self-checking testbench of the sensor output data register group
`timescale 1ns/1ps
`include "sensor_output_params.svh"
module sensor_output_data_regs_tb;
   localparam int GAP = 8; // shortened acquisition spacing
   logic ref_clk = 1'b0; // 125 mhz clock
   logic reset = 1'b1; // sync reset, held 16 cycles
   logic odr_tick = 1'b0; // sample period pulse
   logic adc_done = 1'b0; // converter result strobe
   logic [11:0] adc_data = 12'h000; // converter result
   logic mag_en = 1'b0; // magnitude calculation on
   logic be = 1'b0; // big endian
   logic fr = 1'b0; // fast read
   logic ce = 1'b1; // clock enable
   logic rd_en, wr_en, adc_start, flag;
   logic [7:0] addr, wdata, rdata, next_addr, hi_b;
   logic [1:0] adc_chan, exp_chan = 2'h0, ch;
   logic [11:0] chan_val [4]; // converter values per channel
   logic [7:0] m_temp = 8'h00; // expected register contents
   logic [11:0] m_x = 12'h000, m_y = 12'h000, m_z = 12'h000, m_vector_magnitude = 12'h000;
   logic [15:0] notes [$]; // expected {next address, read data}
   int bad_count = 0, comparisons = 0, cyc = 0, last_start = 0;
   integer seed = 32'h3150;

   // clock and cycle count
   always #4 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;

   host_model host_model_i (.ref_clk_i(ref_clk), .rd_en_o(rd_en), .wr_en_o(wr_en),
      .addr_o(addr), .wdata_o(wdata));

   sensor_output_data_regs #(.GAP_CYCLES(GAP)) sensor_output_data_regs_i (
      .ref_clk_i(ref_clk), .reset_i(reset), .ce_i(ce), .odr_tick_i(odr_tick),
      .adc_done_i(adc_done), .adc_data_i(adc_data), .adc_start_o(adc_start),
      .adc_channel_o(adc_chan), .magnitude_calc_enable_i(mag_en), .endian_select_i(be),
      .fast_read_i(fr), .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr),
      .wdata_i(wdata), .rdata_o(rdata), .next_addr_o(next_addr),
      .data_ready_flag_o(flag));

   // compare a read result or other multi-bit value
   task automatic check_read(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // compare a single flag
   task automatic check_flag(input logic got, input logic exp);
      check_read({15'h0000, got}, {15'h0000, exp});
   endtask

   // verdict and end of run
   task automatic results();
      if (bad_count == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // integer square root by counting up
   function automatic logic [11:0] isqrt(input int s);
      int r;
      r = 0;
      while ((r + 1) * (r + 1) <= s) r++;
      return 12'(r);
   endfunction

   // expected byte at an address under the current byte-order settings
   function automatic logic [7:0] exp_byte(input logic [7:0] a);
      logic [11:0] v;
      logic sg;
      v = 12'h000;
      sg = 1'b1;
      case (a)
         8'h01: return m_temp;
         8'h02, 8'h03: begin
            v = m_vector_magnitude;
            sg = 1'b0;
         end
         8'h04, 8'h05: v = m_x;
         8'h06, 8'h07: v = m_y;
         8'h08, 8'h09: v = m_z;
         default: return 8'h00;
      endcase
      if (!a[0]) return (be || (fr && sg)) ? v[11:4] : v[7:0];
      if (be) return {v[3:0], 4'h0};
      return {sg ? {4{v[11]}} : 4'h0, v[11:8]};
   endfunction

   // expected burst address after a read
   function automatic logic [7:0] exp_next(input logic [7:0] a);
      if (fr && (a == 8'h04 || a == 8'h06 || a == 8'h08)) return a + 8'h02;
      return a + 8'h01;
   endfunction

   // read with a note of the expected answer
   task automatic rd(input logic [7:0] a, input logic more);
      notes.push_back({exp_next(a), exp_byte(a)});
      host_model_i.read(a, more);
   endtask

   // one conversion, with a second tick that must be dropped
   task automatic sample();
      int n;
      for (int c = 0; c < 4; c++) chan_val[c] = 12'($random(seed));
      odr_tick = 1'b1;
      @(posedge ref_clk);
      #1;
      odr_tick = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      odr_tick = 1'b1; // conversion running: ignored
      @(posedge ref_clk);
      #1;
      odr_tick = 1'b0;
      n = 0;
      while (flag !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check_flag(flag, 1'b1);
      m_temp = chan_val[0][7:0] - `TEMP_ZERO_CODE;
      m_x = chan_val[1];
      m_y = chan_val[2];
      m_z = chan_val[3];
      if (mag_en) m_vector_magnitude = isqrt(int'($signed(m_x)) ** 2 + int'($signed(m_y)) ** 2
         + int'($signed(m_z)) ** 2);
   endtask

   // monitor: each taken read answers one cycle later
   always @(posedge ref_clk) begin
      if (!reset && ce && rd_en) begin
         #2;
         check_read({next_addr, rdata}, notes.pop_front());
      end
   end

   // converter model: checks channel order and spacing, answers after three cycles
   always begin
      @(posedge ref_clk);
      #1;
      if (!reset && adc_start) begin
         check_read({14'h0000, adc_chan}, {14'h0000, exp_chan});
         if (adc_chan != 2'h0) check_flag(cyc - last_start >= GAP, 1'b1);
         last_start = cyc;
         exp_chan = exp_chan + 2'h1;
         ch = adc_chan;
         repeat (3) @(posedge ref_clk);
         #1;
         adc_done = 1'b1;
         adc_data = chan_val[ch];
         @(posedge ref_clk);
         #1;
         adc_done = 1'b0;
         adc_data = ~adc_data; // released data does not hold its value
      end
   end

   // watchdog
   initial begin
      #(8 * 20000);
      bad_count++;
      results();
   end

   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      check_flag(flag, 1'b0);
      rd(8'h02, 1'b1);
      rd(8'h03, 1'b0);
      // every byte order with magnitude off and on
      for (int k = 0; k < 4; k++) begin
         be = k[0];
         mag_en = k[1];
         sample();
         ce = 1'b0; // frozen: this read is not taken
         host_model_i.read(8'h05, 1'b0);
         check_flag(flag, 1'b1);
         ce = 1'b1;
         rd(mag_en ? 8'h03 : 8'h05, 1'b0);
         check_flag(flag, 1'b0);
         for (int a = 1; a <= 10; a++) rd(8'(a), a < 10);
         host_model_i.write(8'h04, 8'($random(seed)));
         rd(8'h04, 1'b0);
         hi_b = rdata;
         if (be) begin
            rd(8'h05, 1'b0);
            check_read(16'(host_model_i.unpack_be(hi_b, rdata)), 16'(m_x));
         end
      end
      // fast read bursts in both byte orders
      fr = 1'b1;
      for (int k = 0; k < 2; k++) begin
         be = k[0];
         sample();
         rd(8'h04, 1'b1);
         rd(8'h06, 1'b1);
         rd(8'h08, 1'b1);
         rd(8'h09, 1'b1);
         rd(8'h02, 1'b0);
      end
      repeat (4) @(posedge ref_clk);
      results();
   end
endmodule // sensor_output_data_regs_tb

//--- sensor_output_params.svh
// constants of the sensor output data register group
`ifndef SENSOR_OUTPUT_PARAMS_SVH
`define SENSOR_OUTPUT_PARAMS_SVH
// register offsets
`define ADDR_TEMPERATURE 8'h01
`define ADDR_VECTOR_MAGNITUDE_LOW 8'h02
`define ADDR_VECTOR_MAGNITUDE_HIGH 8'h03
`define ADDR_X_LOW 8'h04
`define ADDR_X_HIGH 8'h05
`define ADDR_Y_LOW 8'h06
`define ADDR_Y_HIGH 8'h07
`define ADDR_Z_LOW 8'h08
`define ADDR_Z_HIGH 8'h09
// reset value of every output register
`define DATA_RESET 8'h00
// code that the temperature channel gives at 25 degrees c
`define TEMP_ZERO_CODE 8'h00
// acquisition channels in conversion order
`define CHAN_TEMP 2'h0
`define CHAN_X 2'h1
`define CHAN_Y 2'h2
`define CHAN_Z 2'h3
// timing: clock period and spacing of acquisitions
`define CLK_PERIOD_NS 8
`define ACQ_GAP_NS 40000
`endif

//--- sensor_output_pkg.sv
// types shared by the sensor output data modules
package sensor_output_pkg;
   // acquisition sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_START,
      SEQ_WAIT
   } seq_state_t;

   // sequencer state
   typedef struct packed {
      seq_state_t st;
      logic [1:0] chan;
      logic [15:0] timer;
      logic [7:0] temp;
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic start;
      logic valid;
   } seq_regs_t;

   // magnitude calculator state
   typedef struct packed {
      logic busy;
      logic [3:0] idx;
      logic [23:0] sum;
      logic [11:0] res;
      logic done;
   } mag_regs_t;

   // output register bank state
   typedef struct packed {
      logic [7:0] temp;
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic [11:0] vector_magnitude;
      logic drdy;
      logic [7:0] rdata;
      logic [7:0] next_addr;
   } bank_regs_t;
endpackage

//--- vector_magnitude_calc.sv
// iterative square root of x*x + y*y + z*z, one result bit per cycle
`timescale 1ns/1ps
module vector_magnitude_calc (
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic [11:0] x_i,
   input wire logic [11:0] y_i,
   input wire logic [11:0] z_i,
   output logic done_o,
   output logic [11:0] mag_o
);
   sensor_output_pkg::mag_regs_t q, d; // state and next state

   // next state: load the sum of squares, then settle bits msb first
   always_comb begin
      logic [11:0] trial;
      trial = '0;
      d = q;
      d.done = 1'b0;
      if (!q.busy && start_i) begin
         d.sum = 24'($signed(x_i) * $signed(x_i)) + 24'($signed(y_i) * $signed(y_i))
            + 24'($signed(z_i) * $signed(z_i));
         d.res = 12'h000;
         d.idx = 4'hb;
         d.busy = 1'b1;
      end else if (q.busy) begin
         trial = q.res | (12'h001 << q.idx);
         if (24'(trial) * 24'(trial) <= q.sum) begin
            d.res = trial; // keep this bit
         end
         if (q.idx == 4'h0) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else begin
            d.idx = q.idx - 4'h1;
         end
      end
   end

   // state register, frozen while ce_i is low
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign done_o = q.done;
   assign mag_o = q.res;

   // the result never overshoots the root
   a_root_bound: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      q.done |-> 24'(q.res) * 24'(q.res) <= q.sum)
      else $error("magnitude larger than root of sum");
endmodule // vector_magnitude_calc
